// file: lcdwf_map.svh
// Purpose: register offsets, field layout and reset values of the waveform bank
// Assumes: byte addresses on the plain register port
// Notes:   definitions only
`ifndef LCDWF_MAP_SVH
`define LCDWF_MAP_SVH

// ============================================================
// register offsets
`define LCDWF_OFS_PINS_0_3    8'h20
`define LCDWF_OFS_PINS_4_7    8'h24
`define LCDWF_OFS_PINS_8_11   8'h28
`define LCDWF_OFS_PINS_12_15  8'h2C
`define LCDWF_OFS_PIN_ENABLE  8'h10
`define LCDWF_OFS_PLANE_SEL   8'h18
`define LCDWF_OFS_CTRL        8'h00
`define LCDWF_OFS_PHASE       8'h04

// ============================================================
// field layout and reset values
`define LCDWF_WORD_RST        32'h0000_0000
`define LCDWF_ENA_RST         16'h0000
`define LCDWF_BYTE_W          8
`define LCDWF_CTRL_ON_BIT     0
`define LCDWF_PHASE_LAST      3'h7
`define LCDWF_ADDR_WORD_LSB   2

`endif

// file: lcdwf_pkg.sv
// Purpose: types shared by the waveform bank
// Assumes: eight phases per frame
// Notes:   types only
package lcdwf_pkg;
  // ============================================================
  // access width of a software write
  typedef enum logic [1:0] {
    LCDWF_SZ_BYTE = 2'b00,
    LCDWF_SZ_HALF = 2'b01,
    LCDWF_SZ_WORD = 2'b10
  } lcdwf_size_t;

  typedef logic [7:0] lcdwf_byte_t;
endpackage : lcdwf_pkg

// file: lcdwf_lane_dec.sv
// Purpose: byte lane enables from address low bits and access size
// Assumes: naturally aligned accesses
// Notes:   purely combinational
`timescale 1ns/10ps
module lcdwf_lane_dec (
  // access description
  input  wire logic [1:0]          addr_lo,
  input  wire lcdwf_pkg::lcdwf_size_t size,
  // lane enables
  output logic [3:0]               lane_en
);
  // ============================================================
  // lane select
  wire [3:0] byte_sel = 4'h1 << addr_lo;
  wire [3:0] half_sel = addr_lo[1] ? 4'hC : 4'h3;

  assign lane_en = (size == lcdwf_pkg::LCDWF_SZ_WORD) ? 4'hF :
                   (size == lcdwf_pkg::LCDWF_SZ_HALF) ? half_sel : byte_sel;
endmodule : lcdwf_lane_dec

// file: lcdwf_pin_drive.sv
// Purpose: one panel pin output: segment or phase bit per active phase
// Assumes: phase index from the frame sequencer
// Notes:   registered output
`timescale 1ns/10ps
module lcdwf_pin_drive (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // pin setup
  input  wire logic [7:0] pin_segment_byte,
  input  wire logic       plane_select,
  input  wire logic       pin_drive_enable,
  input  wire logic       ctrl_on,
  input  wire logic [2:0] phase,
  // pin state
  output logic            panel_pin_ff
);
  // ============================================================
  // selected bit, meaning set by the plane select
  wire bit_sel = pin_segment_byte[phase];
  wire nxt_panel_pin = pin_drive_enable & ctrl_on & bit_sel;

  // pin state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      panel_pin_ff <= 1'b0;
    end else begin
      panel_pin_ff <= nxt_panel_pin;
    end
  end
endmodule : lcdwf_pin_drive

// file: lcdwf_regs.sv
// Function
// R1 - each word holds four pin bytes, lowest pin in the low byte
// R2 - lanes map ascending: bits 7-0, 15-8, 23-16, 31-24
// R3 - eight segments or phases A to H per pin, one-eighth duty
// R4 - element lit only while its phase active and segment bit set
// R5 - front plane: bit 0 segment A up to bit 7 segment H
// R6 - back plane: bit 0 phase A up to bit 7 phase H
// R7 - a one means on or activated, a zero off or deactivated
// R8 - words accept byte, halfword or full-word writes
// R9 - reset clears every waveform word to zero
// R10 - one pin may drive several segments or phases, one bit each
// R11 - plane-select bit one means back plane, zero front plane
// R12 - pin produces a waveform only while its enable bit is set
// R13 - partial writes change only the addressed byte lanes
//
// Purpose: waveform data bank for panel pins 0 to 15 with pin state outputs
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   no wait states; unmapped reads return zero, writes are dropped
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "lcdwf_map.svh"
module lcdwf_regs #(
  parameter int unsigned PINS = 16
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // register port
  input  wire logic [7:0]             addr,
  input  wire logic [31:0]            wdata,
  input  wire lcdwf_pkg::lcdwf_size_t wsize,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [31:0]                 rdata_ff,
  // panel
  output logic [PINS-1:0]             panel_pin_ff,
  output logic [PINS-1:0]             back_plane_ff,
  output logic [2:0]                  phase_ff
);
  localparam int unsigned WORDS = PINS / 4;

  // ============================================================
  // storage
  logic [31:0]     pattern_ff [WORDS];
  logic [PINS-1:0] pin_drive_enable_bits_ff;
  logic [PINS-1:0] plane_select_bits_ff;
  logic            display_controller_on_ff;

  // ============================================================
  // address decode
  function automatic logic is_word(input logic [7:0] a, input logic [7:0] ofs);
    is_word = (a[7:`LCDWF_ADDR_WORD_LSB] == ofs[7:`LCDWF_ADDR_WORD_LSB]);
  endfunction : is_word

  wire       hit_ena   = is_word(addr, `LCDWF_OFS_PIN_ENABLE);
  wire       hit_plane = is_word(addr, `LCDWF_OFS_PLANE_SEL);
  wire       hit_ctrl  = is_word(addr, `LCDWF_OFS_CTRL);
  wire       hit_phase = is_word(addr, `LCDWF_OFS_PHASE);
  wire [3:0] lane_en;

  lcdwf_lane_dec u_lane (
    .addr_lo (addr[1:0]),
    .size    (wsize),
    .lane_en (lane_en)
  );

  // lane mask for partial writes
  wire [31:0] lane_mask = {{8{lane_en[3]}}, {8{lane_en[2]}},
                           {8{lane_en[1]}}, {8{lane_en[0]}}};  // R13

  // ============================================================
  // waveform words, one per four pins
  logic [WORDS-1:0] hit_pat;
  logic [31:0]      rd_pat;

  genvar gw;
  generate
    for (gw = 0; gw < WORDS; gw++) begin : g_word
      wire [7:0]  ofs  = `LCDWF_OFS_PINS_0_3 + 8'(4 * gw);
      wire [31:0] nxt_pattern = (pattern_ff[gw] & ~lane_mask) |
                                (wdata & lane_mask);  // R8 R13
      assign hit_pat[gw] = is_word(addr, ofs);

      // word register
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          pattern_ff[gw] <= `LCDWF_WORD_RST;  // R9
        end else if (wr && hit_pat[gw]) begin
          pattern_ff[gw] <= nxt_pattern;
        end
      end
    end
  endgenerate

  // pick the addressed word for reads
  always_comb begin
    rd_pat = 32'h0000_0000;
    for (int i = 0; i < WORDS; i++) begin
      if (hit_pat[i]) begin
        rd_pat = pattern_ff[i];
      end
    end
  end

  // ============================================================
  // control registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_drive_enable_bits_ff <= '0;
      plane_select_bits_ff     <= '0;
      display_controller_on_ff <= 1'b0;
    end else if (wr) begin
      if (hit_ena) begin
        pin_drive_enable_bits_ff <= (pin_drive_enable_bits_ff & ~lane_mask[PINS-1:0]) |
                                    (wdata[PINS-1:0] & lane_mask[PINS-1:0]);
      end
      if (hit_plane) begin
        plane_select_bits_ff <= (plane_select_bits_ff & ~lane_mask[PINS-1:0]) |
                                (wdata[PINS-1:0] & lane_mask[PINS-1:0]);  // R11
      end
      if (hit_ctrl && lane_en[0]) begin
        display_controller_on_ff <= wdata[`LCDWF_CTRL_ON_BIT];
      end
    end
  end

  // ============================================================
  // phase sequencer, eight phases per frame
  wire [2:0] nxt_phase = (phase_ff == `LCDWF_PHASE_LAST) ? 3'h0 : phase_ff + 3'h1;  // R3

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= 3'h0;
    end else if (display_controller_on_ff) begin
      phase_ff <= nxt_phase;
    end else begin
      phase_ff <= 3'h0;
    end
  end

  // ============================================================
  // pin drivers: byte n%4 of word n/4 feeds pin n
  genvar gp;
  generate
    for (gp = 0; gp < PINS; gp++) begin : g_pin
      wire [7:0] pin_byte = pattern_ff[gp / 4][(gp % 4) * `LCDWF_BYTE_W +: `LCDWF_BYTE_W];  // R1 R2
      lcdwf_pin_drive u_drv (
        .clk              (clk),
        .arst_n           (arst_n),
        .pin_segment_byte (pin_byte),  // R5 R6 R10
        .plane_select     (plane_select_bits_ff[gp]),
        .pin_drive_enable (pin_drive_enable_bits_ff[gp]),  // R12
        .ctrl_on          (display_controller_on_ff),
        .phase            (phase_ff),  // R4 R7
        .panel_pin_ff     (panel_pin_ff[gp])
      );
    end
  endgenerate

  // plane role follows the select bit of each enabled pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      back_plane_ff <= '0;
    end else begin
      back_plane_ff <= plane_select_bits_ff & pin_drive_enable_bits_ff;  // R11
    end
  end

  // ============================================================
  // read data, valid the cycle after the strobe
  wire [31:0] nxt_rdata =
    (|hit_pat)  ? rd_pat :
    hit_ena     ? 32'(pin_drive_enable_bits_ff) :
    hit_plane   ? 32'(plane_select_bits_ff) :
    hit_ctrl    ? 32'(display_controller_on_ff) :
    hit_phase   ? 32'(phase_ff) : 32'h0000_0000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end
endmodule : lcdwf_regs

// file: lcdwf_properties.sv
// Purpose: port checks of the waveform bank
// Assumes: one clock, async low reset
// Notes:   bound to lcdwf_regs below
`timescale 1ns/10ps
module lcdwf_props #(
  parameter int unsigned PINS = 16
) (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   arst_n,
  // register port
  input wire logic [7:0]             addr,
  input wire logic [31:0]            wdata,
  input wire lcdwf_pkg::lcdwf_size_t wsize,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [31:0]            rdata_ff,
  // panel
  input wire logic [PINS-1:0]        panel_pin_ff,
  input wire logic [PINS-1:0]        back_plane_ff,
  input wire logic [2:0]             phase_ff
);
  // ============================================================
  // phase held still for two edges
  logic stood_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) stood_ff <= 1'b0;
    else stood_ff <= $stable(phase_ff);
  end
  property p_rst; $rose(arst_n) |-> rdata_ff == 32'h0 && panel_pin_ff == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not clear after reset");
  property p_idle; !rd |=> rdata_ff == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_word;
    wr && wsize == lcdwf_pkg::LCDWF_SZ_WORD && addr[7:4] == 4'h2 ##1 rd && addr == $past(addr)
      |=> rdata_ff == $past(wdata, 2);
  endproperty
  a_word: assert property (p_word) else $error("word readback wrong");
  property p_lane;
    wr && wsize == lcdwf_pkg::LCDWF_SZ_BYTE && addr == 8'h21 ##1 rd && addr == 8'h20
      |=> rdata_ff[15:8] == $past(wdata[15:8], 2);
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane wrong");
  property p_half;
    wr && wsize == lcdwf_pkg::LCDWF_SZ_HALF && addr == 8'h2A ##1 rd && addr == 8'h28
      |=> rdata_ff[31:16] == $past(wdata[31:16], 2);
  endproperty
  a_half: assert property (p_half) else $error("half lane wrong");
  property p_unmap; rd && addr == 8'h3C |=> rdata_ff == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_phase;
    $changed(phase_ff) && phase_ff != 3'h0 |-> phase_ff == $past(phase_ff) + 3'h1;
  endproperty
  a_phase: assert property (p_phase) else $error("phase step wrong");
  property p_off; stood_ff && $stable(phase_ff) |-> panel_pin_ff == '0; endproperty
  a_off: assert property (p_off) else $error("pin driven while off");
  c_wrap: cover property (phase_ff == 3'h7 ##1 phase_ff == 3'h0);
  c_pin: cover property (|panel_pin_ff);
  c_half: cover property (wr && wsize == lcdwf_pkg::LCDWF_SZ_HALF);
endmodule : lcdwf_props
bind lcdwf_regs lcdwf_props #(.PINS(PINS)) props_u (.clk, .arst_n, .addr, .wdata, .wsize,
  .wr, .rd, .rdata_ff, .panel_pin_ff, .back_plane_ff, .phase_ff);

// file: lcdwf_glass.sv
// Purpose: glass model, lights front segments against active phases
// Assumes: digital pin levels only
// Notes:   no analogue levels
`timescale 1ns/10ps
module lcdwf_glass (
  // panel side
  input wire logic        clk,
  input wire logic [15:0] pin,
  input wire logic [15:0] back,
  // lit front pins
  output logic [15:0]     lit_ff
);
  // element lit while its phase is active and its segment is on
  always_ff @(posedge clk) lit_ff <= pin & ~back & {16{|(pin & back)}};
endmodule : lcdwf_glass

// file: tb.sv
// Purpose: self-checking bench of the waveform bank
// Assumes: model words in mdl
// Notes:   xorshift stimulus from seed 6
`timescale 1ns/10ps
`include "lcdwf_map.svh"
module tb;
  // ============================================================
  // signals and model
  localparam lcdwf_pkg::lcdwf_size_t sz_b = lcdwf_pkg::LCDWF_SZ_BYTE;
  localparam lcdwf_pkg::lcdwf_size_t sz_h = lcdwf_pkg::LCDWF_SZ_HALF;
  localparam lcdwf_pkg::lcdwf_size_t sz_w = lcdwf_pkg::LCDWF_SZ_WORD;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h6, en, pl, rdata_ff, mdl [4] = '{4{32'h0}};
  lcdwf_pkg::lcdwf_size_t wsize = sz_w;
  logic [15:0] pin_ff, bp_ff, lit;
  logic [2:0] phase_ff;
  int error_cnt = 0, checked = 0;
  always #50 clk = ~clk;
  lcdwf_regs #(.PINS(16)) dut_u (.clk, .arst_n, .addr, .wdata, .wsize, .wr, .rd, .rdata_ff,
    .panel_pin_ff(pin_ff), .back_plane_ff(bp_ff), .phase_ff);
  lcdwf_glass glass_u (.clk, .pin(pin_ff), .back(bp_ff), .lit_ff(lit));
  // ============================================================
  // helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] pin_exp(int ph);
    logic [31:0] r = 32'h0;
    for (int n = 0; n < 16; n++) r[n] = en[n] & mdl[n / 4][(n % 4) * 8 + ph];
    return r;
  endfunction : pin_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_t(input logic [7:0] a, input logic [31:0] d, input lcdwf_pkg::lcdwf_size_t s);
    logic [3:0] m = (s == sz_w) ? 4'hF : (s == sz_h) ? 4'h3 << a[1:0] : 4'h1 << a[1:0];
    addr <= a;
    wdata <= d;
    wsize <= s;
    wr <= 1'b1;
    for (int i = 0; i < 4; i++) if (m[i] && a[7:4] == 4'h2) mdl[a[3:2]][i * 8 +: 8] = d[i * 8 +: 8];
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_t
  task automatic rd_t(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata_ff, exp);
    @(posedge clk);
  endtask : rd_t
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // ============================================================
  // watchdog
  initial begin
    #1000000;
    error_cnt++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd_t(8'h20 + 8'(i * 4), 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr_t(8'h20 + 8'(i * 4), xs(), sz_w);
      rd_t(8'h20 + 8'(i * 4), mdl[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr_t(8'h20 + 8'(i), xs(), sz_b);
      rd_t(8'h20, mdl[0]);
    end
    wr_t(8'h2A, xs(), sz_h);
    rd_t(8'h28, mdl[2]);
    wr_t(8'h3C, xs(), sz_w);
    rd_t(8'h3C, 32'h0);
    en = xs();
    pl = xs();
    wr_t(`LCDWF_OFS_PIN_ENABLE, en, sz_w);
    @(posedge clk);
    wr_t(`LCDWF_OFS_PLANE_SEL, pl, sz_w);
    @(posedge clk);
    wr_t(`LCDWF_OFS_CTRL, 32'h1, sz_w);
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      chk(32'(phase_ff), 32'(k % 8));
      chk(32'(bp_ff), pl & en & 32'hFFFF);
      chk(32'(pin_ff), k == 0 ? 32'h0 : pin_exp((k - 1) % 8));
      // glass lights front pins one cycle after the pin states it sees
      if (k > 1)
        chk(32'(lit), pin_exp((k - 2) % 8) & ~pl & 32'hFFFF &
            {32{|(pin_exp((k - 2) % 8) & pl & 32'hFFFF)}});
    end
    @(posedge clk);
    wr_t(`LCDWF_OFS_CTRL, 32'h0, sz_w);
    repeat (2) @(negedge clk);
    chk(32'(pin_ff), 32'h0);
    complete_run();
  end
endmodule : tb
